// >>> bfs_pkg.sv
// Shared constants for the two-way queue pair and its controller
package bfs_pkg;
  // ==========================================================
  // Queue shape
  localparam int DEPTH_DEF = 1024;
  localparam int WIDTH_DEF = 36;
  localparam int AE_OFFSET_DEF = 8;
  localparam int AF_OFFSET_DEF = 8;
  localparam int SYNC_STAGES = 2;
  // ==========================================================
  // Port numbering and queue direction bits
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam logic DIR_A_TO_B = 1'b1;
  localparam logic DIR_B_TO_A = 1'b0;
  // ==========================================================
  // Controller register offsets (byte addresses)
  localparam logic [4:0] REG_TX_A = 5'h00;
  localparam logic [4:0] REG_TX_B = 5'h04;
  localparam logic [4:0] REG_RX_B = 5'h08;
  localparam logic [4:0] REG_RX_A = 5'h0c;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_TX_HI = 5'h14;
  localparam logic [4:0] REG_RX_HI = 5'h18;
  // ==========================================================
  // Reset values
  localparam logic [31:0] READ_DATA_RST = 32'h0000_0000;
  localparam logic [1:0] CHIP_SEL_N_RST = 2'h3;
  // ==========================================================
  // Controller states
  typedef enum logic {
    BFS_IDLE = 1'b0,
    BFS_DONE = 1'b1
  } bfs_state_e;
endpackage

// >>> bfs_link_if.sv
// Pin bundle between the queue pair and the port masters
`timescale 1ns/1ps
interface bfs_link_if #(
  parameter int WIDTH = bfs_pkg::WIDTH_DEF
);
  logic port_a_chip_select_n;
  logic port_b_chip_select_n;
  logic port_a_direction;
  logic port_b_direction;
  logic port_a_mail_select;
  logic port_b_mail_select;
  logic port_a_enable;
  logic port_b_enable;
  logic [WIDTH-1:0] port_a_write_data;
  logic [WIDTH-1:0] port_b_write_data;
  logic [WIDTH-1:0] port_a_read_data;
  logic [WIDTH-1:0] port_b_read_data;
  logic port_a_output_ready;
  logic port_b_output_ready;
  logic port_a_input_ready;
  logic port_b_input_ready;
  logic port_a_almost_empty_n;
  logic port_b_almost_empty_n;
  logic port_a_almost_full_n;
  logic port_b_almost_full_n;

  modport dev (
    input port_a_chip_select_n, port_b_chip_select_n, port_a_direction, port_b_direction,
    input port_a_mail_select, port_b_mail_select, port_a_enable, port_b_enable,
    input port_a_write_data, port_b_write_data,
    output port_a_read_data, port_b_read_data, port_a_output_ready, port_b_output_ready,
    output port_a_input_ready, port_b_input_ready, port_a_almost_empty_n, port_b_almost_empty_n,
    output port_a_almost_full_n, port_b_almost_full_n
  );

  modport host (
    output port_a_chip_select_n, port_b_chip_select_n, port_a_direction, port_b_direction,
    output port_a_mail_select, port_b_mail_select, port_a_enable, port_b_enable,
    output port_a_write_data, port_b_write_data,
    input port_a_read_data, port_b_read_data, port_a_output_ready, port_b_output_ready,
    input port_a_input_ready, port_b_input_ready, port_a_almost_empty_n, port_b_almost_empty_n,
    input port_a_almost_full_n, port_b_almost_full_n
  );
endinterface

// >>> bfs_queue_pair.sv
// Queue pair end: two opposite queues with ready and almost flags
//
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module bfs_queue_pair #(
  parameter int DEPTH = bfs_pkg::DEPTH_DEF,
  parameter int WIDTH = bfs_pkg::WIDTH_DEF,
  parameter int AE_OFFSET = bfs_pkg::AE_OFFSET_DEF,
  parameter int AF_OFFSET = bfs_pkg::AF_OFFSET_DEF
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  bfs_link_if.dev lnk
);
  localparam int AW = $clog2(DEPTH);

  // ==========================================================
  // Parameter checks
  if (DEPTH != 256 && DEPTH != 512 && DEPTH != 1024) begin : g_bad_depth
    $error("queue depth must be 256, 512 or 1024");
  end
  if (AE_OFFSET < 0 || AE_OFFSET >= DEPTH || AF_OFFSET < 0 || AF_OFFSET >= DEPTH) begin : g_bad_ofs
    $error("almost offsets must lie below the depth");
  end

  // ==========================================================
  // Port pins gathered by port number
  logic [1:0] sel;
  logic [1:0] dir;
  logic [WIDTH-1:0] wdata [2];
  logic [1:0] or_w;
  logic [1:0] ir_w;
  logic [1:0] ae_w;
  logic [1:0] af_w;
  logic [WIDTH-1:0] dout_w [2];

  assign sel[0] = ~lnk.port_a_chip_select_n & ~lnk.port_a_mail_select & lnk.port_a_enable;
  assign sel[1] = ~lnk.port_b_chip_select_n & ~lnk.port_b_mail_select & lnk.port_b_enable;
  assign dir[0] = lnk.port_a_direction;
  assign dir[1] = lnk.port_b_direction;
  assign wdata[0] = lnk.port_a_write_data;
  assign wdata[1] = lnk.port_b_write_data;

  // Queue 0 runs A to B, queue 1 runs B to A
  assign lnk.port_a_input_ready = ir_w[0];
  assign lnk.port_a_almost_full_n = af_w[0];
  assign lnk.port_b_output_ready = or_w[0];
  assign lnk.port_b_almost_empty_n = ae_w[0];
  assign lnk.port_b_read_data = dout_w[0];
  assign lnk.port_b_input_ready = ir_w[1];
  assign lnk.port_b_almost_full_n = af_w[1];
  assign lnk.port_a_output_ready = or_w[1];
  assign lnk.port_a_almost_empty_n = ae_w[1];
  assign lnk.port_a_read_data = dout_w[1];

  function automatic logic [AW:0] gray_to_bin(input logic [AW:0] g);
    logic [AW:0] b;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // ==========================================================
  // One queue per direction
  for (genvar q = 0; q < 2; q++) begin : g_queue
    localparam int WP = q;
    localparam int RP = 1 - q;
    localparam logic QDIR = (q == 0) ? bfs_pkg::DIR_A_TO_B : bfs_pkg::DIR_B_TO_A;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_bin_q;
    logic [AW:0] wr_bin_d;
    logic [AW:0] wr_gray_q;
    logic [AW:0] rd_bin_q;
    logic [AW:0] rd_bin_d;
    logic [AW:0] rd_gray_q;
    logic [AW:0] wg_s1_q;
    logic [AW:0] wg_s2_q;
    logic [AW:0] rg_s1_q;
    logic [AW:0] rg_s2_q;
    logic [AW:0] wr_cnt;
    logic [AW:0] rd_cnt;
    logic [AW:0] rd_left;
    logic [WIDTH-1:0] dout_q;
    logic or_q;
    logic ir_q;
    logic ae_n_q;
    logic af_n_q;
    logic push;
    logic pop;
    logic load;

    // Write side, on the shared ref_clk_in
    assign push = sel[WP] & (dir[WP] == QDIR) & ir_q;
    assign wr_bin_d = wr_bin_q + {{AW{1'b0}}, push};
    assign wr_cnt = wr_bin_d - gray_to_bin(rg_s2_q);

    always_ff @(posedge ref_clk_in) begin
      if (clk_en_in && push) begin
        mem[wr_bin_q[AW-1:0]] <= wdata[WP];
      end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        wr_bin_q <= '0;
        wr_gray_q <= '0;
      end else if (clk_en_in) begin
        wr_bin_q <= wr_bin_d;
        wr_gray_q <= wr_bin_d ^ (wr_bin_d >> 1);
      end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        rg_s1_q <= '0;
        rg_s2_q <= '0;
      end else if (clk_en_in) begin
        rg_s1_q <= rd_gray_q;
        rg_s2_q <= rg_s1_q;
      end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        ir_q <= 1'b0;
        af_n_q <= 1'b0;
      end else if (clk_en_in) begin
        ir_q <= wr_cnt != (AW+1)'(DEPTH);
        af_n_q <= wr_cnt < (AW+1)'(DEPTH - AF_OFFSET);
      end
    end

    // Read side, on the shared ref_clk_in
    assign pop = sel[RP] & (dir[RP] == QDIR) & or_q;
    assign rd_cnt = gray_to_bin(wg_s2_q) - rd_bin_q;
    assign load = (rd_cnt != '0) & (~or_q | pop);
    assign rd_bin_d = rd_bin_q + {{AW{1'b0}}, load};
    assign rd_left = rd_cnt - {{AW{1'b0}}, load};

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        wg_s1_q <= '0;
        wg_s2_q <= '0;
      end else if (clk_en_in) begin
        wg_s1_q <= wr_gray_q;
        wg_s2_q <= wg_s1_q;
      end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        rd_bin_q <= '0;
        rd_gray_q <= '0;
      end else if (clk_en_in) begin
        rd_bin_q <= rd_bin_d;
        rd_gray_q <= rd_bin_d ^ (rd_bin_d >> 1);
      end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        or_q <= 1'b0;
        dout_q <= '0;
      end else if (clk_en_in) begin
        if (load) begin
          or_q <= 1'b1;
          dout_q <= mem[rd_bin_q[AW-1:0]];
        end else if (pop) begin
          or_q <= 1'b0;
        end
      end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        ae_n_q <= 1'b0;
      end else if (clk_en_in) begin
        ae_n_q <= rd_left > (AW+1)'(AE_OFFSET);
      end
    end

    assign or_w[q] = or_q;
    assign ir_w[q] = ir_q;
    assign ae_w[q] = ae_n_q;
    assign af_w[q] = af_n_q;
    assign dout_w[q] = dout_q;
  end
endmodule

// >>> bfs_port_master.sv
// Port masters for both queue ports, ordered over Avalon-MM
`timescale 1ns/1ps
module bfs_port_master #(
  parameter int WIDTH = bfs_pkg::WIDTH_DEF
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  bfs_link_if.host lnk
);
  localparam int HW = WIDTH - 32;

  // ==========================================================
  // Parameter checks
  if (WIDTH <= 32 || WIDTH > 64) begin : g_bad_width
    $error("word width must lie in 33 to 64");
  end

  // ==========================================================
  // Port signals gathered by port number
  logic [1:0] cs_n_q;
  logic [1:0] dir_q;
  logic [1:0] en_q;
  logic [WIDTH-1:0] wdata_q [2];
  logic [WIDTH-1:0] rdata [2];
  logic [1:0] in_rdy;
  logic [1:0] out_rdy;
  logic [7:0] status;
  logic [HW-1:0] tx_hi_q;
  logic [HW-1:0] rx_hi_q;
  logic [31:0] rdata_q;
  logic wait_q;
  bfs_pkg::bfs_state_e state_q;
  logic port_op;
  logic op_ok;
  logic op_port;
  logic op_dir;

  assign lnk.port_a_chip_select_n = cs_n_q[0];
  assign lnk.port_b_chip_select_n = cs_n_q[1];
  assign lnk.port_a_direction = dir_q[0];
  assign lnk.port_b_direction = dir_q[1];
  assign lnk.port_a_enable = en_q[0];
  assign lnk.port_b_enable = en_q[1];
  assign lnk.port_a_write_data = wdata_q[0];
  assign lnk.port_b_write_data = wdata_q[1];
  assign lnk.port_a_mail_select = 1'b0;
  assign lnk.port_b_mail_select = 1'b0;
  assign rdata[0] = lnk.port_a_read_data;
  assign rdata[1] = lnk.port_b_read_data;
  assign in_rdy = {lnk.port_b_input_ready, lnk.port_a_input_ready};
  assign out_rdy = {lnk.port_b_output_ready, lnk.port_a_output_ready};
  assign status = {lnk.port_b_almost_full_n, lnk.port_b_almost_empty_n, lnk.port_b_input_ready,
                   lnk.port_b_output_ready, lnk.port_a_almost_full_n, lnk.port_a_almost_empty_n,
                   lnk.port_a_input_ready, lnk.port_a_output_ready};
  assign avs_readdata_out = rdata_q;
  assign avs_waitrequest_out = wait_q;

  // ==========================================================
  // Request decode
  always_comb begin
    port_op = 1'b0;
    op_port = 1'b0;
    op_dir = 1'b0;
    if (avs_write_in && avs_address_in == bfs_pkg::REG_TX_A) begin
      port_op = 1'b1;
      op_dir = bfs_pkg::DIR_A_TO_B;
    end else if (avs_write_in && avs_address_in == bfs_pkg::REG_TX_B) begin
      port_op = 1'b1;
      op_port = 1'b1;
      op_dir = bfs_pkg::DIR_B_TO_A;
    end else if (avs_read_in && avs_address_in == bfs_pkg::REG_RX_B) begin
      port_op = 1'b1;
      op_port = 1'b1;
      op_dir = bfs_pkg::DIR_A_TO_B;
    end else if (avs_read_in && avs_address_in == bfs_pkg::REG_RX_A) begin
      port_op = 1'b1;
      op_dir = bfs_pkg::DIR_B_TO_A;
    end
    op_ok = avs_write_in ? in_rdy[op_port] : out_rdy[op_port];
  end

  // ==========================================================
  // Transfer sequencing
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_q <= bfs_pkg::BFS_IDLE;
      wait_q <= 1'b1;
      cs_n_q <= bfs_pkg::CHIP_SEL_N_RST;
      dir_q <= '0;
      en_q <= '0;
      wdata_q[0] <= '0;
      wdata_q[1] <= '0;
      rdata_q <= bfs_pkg::READ_DATA_RST;
      tx_hi_q <= '0;
      rx_hi_q <= '0;
    end else if (clk_en_in) begin
      unique case (state_q)
        bfs_pkg::BFS_IDLE: begin
          if ((avs_read_in || avs_write_in) && (!port_op || op_ok)) begin
            state_q <= bfs_pkg::BFS_DONE;
            wait_q <= 1'b0;
            if (port_op) begin
              cs_n_q[op_port] <= 1'b0;
              dir_q[op_port] <= op_dir;
              en_q[op_port] <= 1'b1;
              if (avs_write_in) begin
                wdata_q[op_port] <= {tx_hi_q, avs_writedata_in};
              end else begin
                rdata_q <= rdata[op_port][31:0];
                rx_hi_q <= rdata[op_port][WIDTH-1:32];
              end
            end else if (avs_write_in) begin
              if (avs_address_in == bfs_pkg::REG_TX_HI) begin
                tx_hi_q <= avs_writedata_in[HW-1:0];
              end
            end else if (avs_address_in == bfs_pkg::REG_STATUS) begin
              rdata_q <= {24'h00_0000, status};
            end else if (avs_address_in == bfs_pkg::REG_RX_HI) begin
              rdata_q <= {{(64 - WIDTH){1'b0}}, rx_hi_q};
            end else begin
              rdata_q <= bfs_pkg::READ_DATA_RST;
            end
          end
        end
        bfs_pkg::BFS_DONE: begin
          state_q <= bfs_pkg::BFS_IDLE;
          wait_q <= 1'b1;
          cs_n_q <= bfs_pkg::CHIP_SEL_N_RST;
          en_q <= '0;
        end
      endcase
    end
  end
endmodule

// >>> bfs_flag_props.sv
// Flag timing checks on the link between the queue pair and the port masters
`timescale 1ns/1ps
module bfs_flag_props (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic port_a_chip_select_n,
  input wire logic port_b_chip_select_n,
  input wire logic port_a_direction,
  input wire logic port_b_direction,
  input wire logic port_a_enable,
  input wire logic port_b_enable,
  input wire logic port_a_output_ready,
  input wire logic port_b_output_ready,
  input wire logic port_a_input_ready,
  input wire logic port_b_input_ready,
  input wire logic port_b_almost_empty_n,
  input wire logic port_a_almost_full_n
);
  // ==========================================================
  // Accepted accesses
  logic wab;
  logic rab;
  logic wba;
  logic rba;
  assign wab = !port_a_chip_select_n && port_a_enable && port_a_direction && port_a_input_ready;
  assign rab = !port_b_chip_select_n && port_b_enable && port_b_direction && port_b_output_ready;
  assign wba = !port_b_chip_select_n && port_b_enable && !port_b_direction && port_b_input_ready;
  assign rba = !port_a_chip_select_n && port_a_enable && !port_a_direction && port_a_output_ready;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // ==========================================================
  // Assertions
  a_fall_thru_b: assert property (wab && !port_b_output_ready |-> ##[1:4] port_b_output_ready)
    else $error("port B output ready late");
  a_fall_thru_a: assert property (wba && !port_a_output_ready |-> ##[1:4] port_a_output_ready)
    else $error("port A output ready late");
  a_room_back_a: assert property (rab && !port_a_input_ready |-> ##[1:4] port_a_input_ready)
    else $error("port A input ready late");
  a_room_back_b: assert property (rba && !port_b_input_ready |-> ##[1:4] port_b_input_ready)
    else $error("port B input ready late");
  a_empty_by_read: assert property ($fell(port_b_output_ready) |-> $past(rab))
    else $error("port B output ready fell without read");
  a_full_by_write: assert property ($fell(port_a_input_ready) |-> $past(wab))
    else $error("port A input ready fell without write");
  a_ae_needs_word: assert property (port_b_almost_empty_n |-> port_b_output_ready)
    else $error("almost empty high with no word");
  a_full_is_af: assert property (!port_a_input_ready |-> !port_a_almost_full_n)
    else $error("full queue without almost full");
  a_af_two_edges: assert property ($rose(port_a_almost_full_n) && $past(port_b_output_ready, 4) |-> $past(rab, 4))
    else $error("port A almost full released too soon after read");
  // ==========================================================
  // Coverage
  c_first_word: cover property (wab && !port_b_output_ready);
  c_full_read: cover property (rab && !port_a_input_ready);
  c_af_release: cover property ($rose(port_a_almost_full_n));
endmodule

// >>> bidir_fifo_flag_sync_test.sv
// Self-checking bench: queue pair driven by its port masters over Avalon-MM
`timescale 1ns/1ps
module bidir_fifo_flag_sync_test;
  localparam int DEPTH = 256;
  localparam int AEO = 8;
  localparam int AFO = 8;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic [4:0] av_addr = 5'h00;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wdata = 32'h0000_0000;
  logic [31:0] av_rdata;
  logic av_wait;
  logic [31:0] rd;
  logic [35:0] q_ab[$];
  logic [35:0] q_ba[$];
  int num_errors = 0;
  int checked = 0;
  int seed = 41;
  bfs_link_if #(.WIDTH(36)) link ();
  always #10 ref_clk_in = ~ref_clk_in;
  // ==========================================================
  // Ends and checker
  bfs_queue_pair #(.DEPTH(DEPTH), .WIDTH(36), .AE_OFFSET(AEO), .AF_OFFSET(AFO)) bfs_queue_pair_inst (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in), .lnk(link));
  bfs_port_master #(.WIDTH(36)) bfs_port_master_inst (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in), .avs_address_in(av_addr),
    .avs_read_in(av_rd), .avs_write_in(av_wr), .avs_writedata_in(av_wdata), .avs_readdata_out(av_rdata),
    .avs_waitrequest_out(av_wait), .lnk(link));
  bfs_flag_props bfs_flag_props_inst (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .port_a_chip_select_n(link.port_a_chip_select_n), .port_b_chip_select_n(link.port_b_chip_select_n),
    .port_a_direction(link.port_a_direction), .port_b_direction(link.port_b_direction),
    .port_a_enable(link.port_a_enable), .port_b_enable(link.port_b_enable),
    .port_a_output_ready(link.port_a_output_ready), .port_b_output_ready(link.port_b_output_ready),
    .port_a_input_ready(link.port_a_input_ready), .port_b_input_ready(link.port_b_input_ready),
    .port_b_almost_empty_n(link.port_b_almost_empty_n), .port_a_almost_full_n(link.port_a_almost_full_n));
  // ==========================================================
  // Checking and bus tasks
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic av(input logic wr, input logic [4:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    av_addr <= addr;
    av_wr <= wr;
    av_rd <= ~wr;
    av_wdata <= data;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (av_wait !== 1'b0 && n < 5000);
    if (n >= 5000) begin
      num_errors++;
      $display("[ERR] bus answer missing");
    end
    rd = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask
  // ==========================================================
  // Model of the flags
  function automatic logic [3:0] nib(input int rd_t, input int wr_t);
    int rm;
    int wm;
    rm = (rd_t > 0) ? rd_t - 1 : 0;
    wm = (wr_t > 0) ? wr_t - 1 : 0;
    return {wm <= DEPTH - (AFO + 1), rm > AEO, wm < DEPTH, rd_t > 0};
  endfunction
  function automatic int tot(input bit ab);
    return ab ? q_ab.size() : q_ba.size();
  endfunction
  function automatic bit key(input int t);
    return t inside {0, 1, AEO + 1, AEO + 2, DEPTH - AFO, DEPTH - AFO + 1, DEPTH, DEPTH + 1};
  endfunction
  task automatic status_chk();
    repeat (5) @(posedge ref_clk_in);
    av(1'b0, bfs_pkg::REG_STATUS, 32'h0000_0000);
    chk("status", {28'h0, nib(q_ab.size(), q_ba.size()), nib(q_ba.size(), q_ab.size())}, {4'h0, rd});
  endtask
  task automatic put_word(input bit ab);
    logic [31:0] hi;
    logic [31:0] d;
    hi = $random(seed);
    d = $random(seed);
    av(1'b1, bfs_pkg::REG_TX_HI, hi);
    av(1'b1, ab ? bfs_pkg::REG_TX_A : bfs_pkg::REG_TX_B, d);
    if (ab) begin
      q_ab.push_back({hi[3:0], d});
    end else begin
      q_ba.push_back({hi[3:0], d});
    end
    if (key(tot(ab))) begin
      status_chk();
    end
  endtask
  task automatic get_word(input bit ab);
    logic [35:0] w;
    logic [31:0] lo;
    av(1'b0, ab ? bfs_pkg::REG_RX_B : bfs_pkg::REG_RX_A, 32'h0000_0000);
    lo = rd;
    av(1'b0, bfs_pkg::REG_RX_HI, 32'h0000_0000);
    if (ab) begin
      w = q_ab.pop_front();
    end else begin
      w = q_ba.pop_front();
    end
    chk("queue word", w, {rd[3:0], lo});
    if (key(tot(ab))) begin
      status_chk();
    end
  endtask
  task automatic run_dir(input bit ab);
    status_chk();
    for (int i = 0; i <= DEPTH; i++) begin
      put_word(ab);
    end
    clk_en_in <= 1'b0;
    repeat (8) @(posedge ref_clk_in);
    clk_en_in <= 1'b1;
    status_chk();
    get_word(ab);
    put_word(ab);
    while (tot(ab) > 0) begin
      get_word(ab);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (5) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    av(1'b0, 5'h1c, 32'h0000_0000);
    chk("unmapped read", 36'h0, {4'h0, rd});
    run_dir(1'b1);
    run_dir(1'b0);
    give_verdict();
  end
  initial begin
    repeat (40000) @(posedge ref_clk_in);
    num_errors++;
    $display("[ERR] watchdog expired");
    give_verdict();
  end
endmodule
